// ### verilog/mbm_buffer_manager.sv
// mbm_buffer_manager: stores and fetches remote-terminal message records in shared ram
// assumes a protocol engine on mclk, a word ram with one-cycle read latency that
// never stalls, and an avalon-mm master on the register port
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mbm_buffer_manager (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output wire logic        avs_waitrequest,
  output wire logic [31:0] avs_readdata,
  input  wire logic        cmd_valid,
  input  wire logic [4:0]  cmd_desc,
  input  wire logic        cmd_tx,
  input  wire logic        cmd_broadcast_flag,
  input  wire logic        cmd_mode,
  input  wire logic [4:0]  cmd_code,
  input  wire logic [5:0]  cmd_wc,
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_word,
  input  wire logic        tx_req,
  output var  logic        tx_valid,
  output var  logic [15:0] tx_word,
  input  wire logic        msg_end,
  input  wire logic [4:0]  msg_err,
  input  wire logic        tt_tick,
  output var  logic [15:0] ram_addr,
  output var  logic [15:0] ram_wdata,
  output var  logic        ram_we,
  output var  logic        ram_re,
  input  wire logic [15:0] ram_rdata
);

  typedef enum {S_IDLE, S_DATA, S_INFO, S_TTAG} mbm_state_t;

  mbm_state_t              state;
  logic [2:0]              ctrl;
  logic [3:0]              events;
  logic [3:0]              ev_set;
  logic [15:0]             ttag;
  mbm_pkg::mbm_buf_mode_t  d_mode [32];
  logic                    d_sel  [32];
  logic [7:0]              d_cnt  [32];
  logic [15:0]             d_pa   [32];
  logic [15:0]             d_pb   [32];
  logic [15:0]             d_pc   [32];
  logic [15:0]             mc_data [32];
  logic [4:0]              cur_idx;
  mbm_pkg::mbm_buf_mode_t  cur_m;
  logic                    cur_tx;
  logic                    cur_broadcast_flag;
  logic                    cur_mode;
  logic                    cur_simple;
  logic                    cur_bsep;
  logic [5:0]              cur_wc;
  logic [5:0]              got;
  logic [4:0]              err_q;
  logic [15:0]             tt_cap;
  logic [15:0]             rec_ptr;
  logic [15:0]             data_ptr;
  logic                    rd_pend;
  logic                    message_error_flag;
  logic [15:0]             message_info_word;
  logic [15:0]             rec_len;
  logic [15:0]             circ1_next;
  logic                    circ1_wrap;
  logic [7:0]              cur_cnt;
  logic                    cur_sel;
  logic                    next_bsep;
  logic [15:0]             next_rec;
  logic [15:0]             next_data;
  logic [5:0]              next_wc;
  logic [31:0]             rd_value;
  logic                    reg_wr;
  logic [1:0]              wr_field;

  // merge a 16-bit register with written bytes
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  // address window decodes
  function automatic logic is_desc(input logic [9:0] a);
    is_desc = a[9] == mbm_pkg::ADDR_DESC[9];
  endfunction : is_desc

  function automatic logic is_mc(input logic [9:0] a);
    is_mc = a[9:7] == mbm_pkg::ADDR_MC_BASE[9:7];
  endfunction : is_mc

  mbm_avs_port u_avs (
    .mclk            (mclk),
    .rstn            (rstn),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .rd_value        (rd_value),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .reg_wr          (reg_wr)
  );

  assign wr_field = avs_address[3:2];
  assign cur_cnt  = d_cnt[cur_idx];
  assign cur_sel  = d_sel[cur_idx];

  // register read mux, unmapped reads return zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (is_desc(avs_address))
    begin
      case (wr_field)
        2'h0: rd_value[15:0] = {d_cnt[avs_address[8:4]], 5'h00,
                                d_sel[avs_address[8:4]], d_mode[avs_address[8:4]]};
        2'h1: rd_value[15:0] = d_pa[avs_address[8:4]];
        2'h2: rd_value[15:0] = d_pb[avs_address[8:4]];
        default: rd_value[15:0] = d_pc[avs_address[8:4]];
      endcase
    end
    else if (is_mc(avs_address))
      rd_value[15:0] = mc_data[avs_address[6:2]];
    else
    begin
      case (avs_address)
        mbm_pkg::ADDR_CTRL:   rd_value[2:0]  = ctrl;
        mbm_pkg::ADDR_STATUS: rd_value[0]    = state != S_IDLE;
        mbm_pkg::ADDR_EVENT:  rd_value[3:0]  = events;
        mbm_pkg::ADDR_TTAG:   rd_value[15:0] = ttag;
        default:              rd_value       = 32'h0000_0000;
      endcase
    end
  end

  // control register
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      ctrl <= mbm_pkg::CTRL_RESET;
    else if (reg_wr && avs_address == mbm_pkg::ADDR_CTRL && avs_byteenable[0])
      ctrl <= avs_writedata[2:0];
  end

  // free-running time-tag counter
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      ttag <= 16'h0000;
    else if (tt_tick)
      ttag <= ttag + 16'h0001;
  end

  // command set-up: pick record start and data start from the descriptor
  always_comb
  begin
    next_bsep = ctrl[mbm_pkg::CTRL_BSEP_BIT] && cmd_broadcast_flag && !cmd_tx &&
                (d_mode[cmd_desc] == mbm_pkg::MBM_INDEXED ||
                 d_mode[cmd_desc] == mbm_pkg::MBM_PINGPONG);
    if (next_bsep)
      next_rec = d_pc[cmd_desc];
    else if (d_mode[cmd_desc] == mbm_pkg::MBM_PINGPONG)
      next_rec = d_sel[cmd_desc] ? d_pb[cmd_desc] : d_pa[cmd_desc];
    else if (d_mode[cmd_desc] == mbm_pkg::MBM_CIRC2)
      next_rec = d_pc[cmd_desc];
    else
      next_rec = d_pa[cmd_desc];
    if (d_mode[cmd_desc] == mbm_pkg::MBM_CIRC2 && !next_bsep)
      next_data = d_pa[cmd_desc];
    else
      next_data = next_rec + mbm_pkg::HDR_WORDS;
    if (cmd_mode)
      next_wc = (cmd_code >= mbm_pkg::MODE_NODATA_LIMIT) ? 6'h01 : 6'h00;
    else
      next_wc = cmd_wc;
  end

  // info word and record length of the finished message
  always_comb
  begin
    message_error_flag = |err_q;
    message_info_word = 16'h0000;
    message_info_word[mbm_pkg::MIW_ERR_LSB +: 5] = err_q;
    if (ctrl[mbm_pkg::CTRL_BFLAG_BIT])
      message_info_word[mbm_pkg::MIW_GAP_BIT] = cur_broadcast_flag;
    message_info_word[mbm_pkg::MIW_MESSAGE_ERROR_FLAG_BIT] = message_error_flag;
    message_info_word[mbm_pkg::MIW_MODE_BIT] = cur_mode;
    message_info_word[mbm_pkg::MIW_TX_BIT] = cur_tx;
    message_info_word[mbm_pkg::MIW_WC_LSB +: 6] = got;
    rec_len = (message_error_flag && !cur_tx) ? mbm_pkg::HDR_WORDS
                                : mbm_pkg::HDR_WORDS + {10'h000, got};
    circ1_next = d_pa[cur_idx] + rec_len;
    circ1_wrap = circ1_next >= d_pc[cur_idx];
  end

  // message sequencer
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state      <= S_IDLE;
      cur_idx    <= 5'h00;
      cur_m      <= mbm_pkg::MBM_INDEXED;
      cur_tx     <= 1'b0;
      cur_broadcast_flag  <= 1'b0;
      cur_mode   <= 1'b0;
      cur_simple <= 1'b0;
      cur_bsep   <= 1'b0;
      cur_wc     <= 6'h00;
      got        <= 6'h00;
      err_q      <= 5'h00;
      tt_cap     <= 16'h0000;
      rec_ptr    <= 16'h0000;
      data_ptr   <= 16'h0000;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (cmd_valid)
          begin
            state      <= S_DATA;
            cur_idx    <= cmd_desc;
            cur_m      <= d_mode[cmd_desc];
            cur_tx     <= cmd_tx;
            cur_broadcast_flag  <= cmd_broadcast_flag;
            cur_mode   <= cmd_mode;
            cur_simple <= cmd_mode && ctrl[mbm_pkg::CTRL_SIMPLE_BIT];
            cur_bsep   <= next_bsep;
            cur_wc     <= next_wc;
            got        <= 6'h00;
            tt_cap     <= ttag;
            rec_ptr    <= next_rec;
            data_ptr   <= next_data;
          end
        S_DATA:
        begin
          if ((rx_valid && !cur_tx) || (tx_req && cur_tx))
            got <= (got < next_wc_cap(cur_mode, cur_wc)) ? got + 6'h01 : got;
          if (msg_end)
          begin
            err_q <= msg_err;
            state <= cur_simple ? S_IDLE : S_INFO;
          end
        end
        S_INFO:
          state <= S_TTAG;
        S_TTAG:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // largest data word count a message may move; low mode codes move none
  function automatic logic [5:0] next_wc_cap(input logic mode_cmd, input logic [5:0] mode_wc);
    next_wc_cap = mode_cmd ? mode_wc : mbm_pkg::MAX_DATA_WORDS;
  endfunction : next_wc_cap

  // shared ram port: data words, then info word, then time tag
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ram_addr  <= 16'h0000;
      ram_wdata <= 16'h0000;
      ram_we    <= 1'b0;
      ram_re    <= 1'b0;
    end
    else
    begin
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      if (state == S_DATA && !cur_simple && rx_valid && !cur_tx)
      begin
        ram_addr  <= data_ptr + {10'h000, got};
        ram_wdata <= rx_word;
        ram_we    <= 1'b1;
      end
      else if (state == S_DATA && !cur_simple && tx_req && cur_tx)
      begin
        ram_addr <= data_ptr + {10'h000, got};
        ram_re   <= 1'b1;
      end
      else if (state == S_INFO)
      begin
        ram_addr  <= rec_ptr;
        ram_wdata <= message_info_word;
        ram_we    <= 1'b1;
      end
      else if (state == S_TTAG)
      begin
        ram_addr  <= rec_ptr + 16'h0001;
        ram_wdata <= tt_cap;
        ram_we    <= 1'b1;
      end
    end
  end

  // transmit words: from ram two cycles after ram_re, or from the table
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rd_pend  <= 1'b0;
      tx_valid <= 1'b0;
      tx_word  <= 16'h0000;
    end
    else
    begin
      rd_pend  <= ram_re;
      tx_valid <= 1'b0;
      if (rd_pend)
      begin
        tx_word  <= ram_rdata;
        tx_valid <= 1'b1;
      end
      else if (state == S_DATA && cur_simple && tx_req && cur_tx)
      begin
        tx_word  <= mc_data[cur_idx];
        tx_valid <= 1'b1;
      end
    end
  end

  // mode command data table, written by host or by received mode data
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 32; i++)
        mc_data[i] <= 16'h0000;
    end
    else if (state == S_DATA && cur_simple && rx_valid && !cur_tx)
      mc_data[cur_idx] <= rx_word;
    else if (reg_wr && is_mc(avs_address))
      mc_data[avs_address[6:2]] <= be_merge(mc_data[avs_address[6:2]], avs_writedata,
                                            avs_byteenable);
  end

  // descriptor table: host writes, then device updates after each record that is not broadcast-separated
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        d_mode[i] <= mbm_pkg::MBM_INDEXED;
        d_sel[i]  <= 1'b0;
        d_cnt[i]  <= 8'h00;
        d_pa[i]   <= 16'h0000;
        d_pb[i]   <= 16'h0000;
        d_pc[i]   <= 16'h0000;
      end
    end
    else
    begin
      if (reg_wr && is_desc(avs_address))
      begin
        case (wr_field)
          2'h0:
          begin
            if (avs_byteenable[0])
            begin
              d_mode[avs_address[8:4]] <= mbm_pkg::mbm_buf_mode_t'(avs_writedata[1:0]);
              d_sel[avs_address[8:4]]  <= avs_writedata[mbm_pkg::DCFG_SEL_BIT];
            end
            if (avs_byteenable[1])
              d_cnt[avs_address[8:4]] <= avs_writedata[mbm_pkg::DCFG_CNT_LSB +: 8];
          end
          2'h1: d_pa[avs_address[8:4]] <= be_merge(d_pa[avs_address[8:4]], avs_writedata,
                                                   avs_byteenable);
          2'h2: d_pb[avs_address[8:4]] <= be_merge(d_pb[avs_address[8:4]], avs_writedata,
                                                   avs_byteenable);
          default: d_pc[avs_address[8:4]] <= be_merge(d_pc[avs_address[8:4]],
                                                      avs_writedata, avs_byteenable);
        endcase
      end
      if (state == S_TTAG && !cur_bsep)
      begin
        case (cur_m)
          mbm_pkg::MBM_INDEXED:
            if (cur_cnt != 8'h00 && !message_error_flag)
            begin
              d_pa[cur_idx]  <= d_pa[cur_idx] + rec_len;
              d_cnt[cur_idx] <= cur_cnt - 8'h01;
            end
          mbm_pkg::MBM_PINGPONG:
            if (!message_error_flag)
              d_sel[cur_idx] <= !cur_sel;
          mbm_pkg::MBM_CIRC1:
            d_pa[cur_idx] <= circ1_wrap ? d_pb[cur_idx] : circ1_next;
          mbm_pkg::MBM_CIRC2:
          begin
            d_pc[cur_idx] <= d_pc[cur_idx] + mbm_pkg::HDR_WORDS;
            d_pa[cur_idx] <= d_pa[cur_idx] + rec_len - mbm_pkg::HDR_WORDS;
            if (cur_cnt != 8'h00)
              d_cnt[cur_idx] <= cur_cnt - 8'h01;
          end
          default:
            d_sel[cur_idx] <= cur_sel;
        endcase
      end
    end
  end

  // completion events
  always_comb
  begin
    ev_set = 4'h0;
    if (state == S_TTAG)
    begin
      ev_set[mbm_pkg::EV_IDX_DONE] = !cur_bsep && cur_m == mbm_pkg::MBM_INDEXED &&
                                     cur_cnt == 8'h01 && !message_error_flag;
      ev_set[mbm_pkg::EV_CIRC1_FULL] = cur_m == mbm_pkg::MBM_CIRC1 && circ1_wrap;
      ev_set[mbm_pkg::EV_CIRC2_DONE] = cur_m == mbm_pkg::MBM_CIRC2 &&
                                       cur_cnt == 8'h01;
      ev_set[mbm_pkg::EV_MSG_ERR] = message_error_flag;
    end
  end

  // sticky events, a new event wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      events <= mbm_pkg::EV_RESET;
    else if (reg_wr && avs_address == mbm_pkg::ADDR_EVENT && avs_byteenable[0])
      events <= (events & ~avs_writedata[3:0]) | ev_set;
    else
      events <= events | ev_set;
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_tt_capture;
    state == S_IDLE && cmd_valid |=> tt_cap == $past(ttag);
  endproperty
  a_tt_capture: assert property (p_tt_capture) else $error("time tag not captured");

  property p_info_then_tag;
    state == S_INFO |=> ram_we && ram_addr == $past(rec_ptr) && ram_wdata == $past(message_info_word)
                        ##1 ram_we && ram_addr == $past(rec_ptr, 2) + 16'h0001
                        && ram_wdata == tt_cap;
  endproperty
  a_info_then_tag: assert property (p_info_then_tag) else $error("header order wrong");

  property p_rx_store;
    state == S_DATA && rx_valid && !cur_tx && !cur_simple
      |=> ram_we && ram_wdata == $past(rx_word);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("receive word not stored");

  property p_tx_fetch;
    state == S_DATA && tx_req && cur_tx && !cur_simple |=> ram_re ##2 tx_valid;
  endproperty
  a_tx_fetch: assert property (p_tx_fetch) else $error("transmit fetch missing");

  property p_pp_switch;
    state == S_TTAG && cur_m == mbm_pkg::MBM_PINGPONG && !cur_bsep
      |=> cur_sel == ($past(cur_sel) ^ !$past(message_error_flag));
  endproperty
  a_pp_switch: assert property (p_pp_switch) else $error("ping-pong select wrong");

  property p_single_msg;
    state == S_TTAG && cur_m == mbm_pkg::MBM_INDEXED && cur_cnt == 8'h00
      |=> $stable(d_pa[cur_idx]);
  endproperty
  a_single_msg: assert property (p_single_msg) else $error("single mode pointer moved");

  property p_simple_no_ram;
    state == S_DATA && cur_simple |=> !ram_we && !ram_re;
  endproperty
  a_simple_no_ram: assert property (p_simple_no_ram) else $error("mode data hit ram");

  property p_err_len;
    state == S_TTAG && message_error_flag && !cur_tx |-> rec_len == mbm_pkg::HDR_WORDS;
  endproperty
  a_err_len: assert property (p_err_len) else $error("errored record too long");

  property p_idx_done;
    state == S_TTAG && cur_m == mbm_pkg::MBM_INDEXED && !cur_bsep && cur_cnt == 8'h01
      && !message_error_flag |=> events[mbm_pkg::EV_IDX_DONE] && cur_cnt == 8'h00;
  endproperty
  a_idx_done: assert property (p_idx_done) else $error("indexed done missing");

  property p_pp_size;
    state == S_TTAG && cur_m == mbm_pkg::MBM_PINGPONG |-> rec_len <= mbm_pkg::PP_BUF_WORDS;
  endproperty
  a_pp_size: assert property (p_pp_size) else $error("ping-pong record overflow");

  c_rx_msg: cover property (state == S_DATA && rx_valid ##[1:40] state == S_TTAG);
  c_tx_msg: cover property (tx_valid ##[1:40] state == S_TTAG);
  c_circ1_wrap: cover property (state == S_TTAG && cur_m == mbm_pkg::MBM_CIRC1 && circ1_wrap);
  c_bsep: cover property (state == S_TTAG && cur_bsep);

endmodule : mbm_buffer_manager
`default_nettype wire

// ### verilog/mbm_pkg.sv
// mbm_pkg: register map, field positions, reset values and buffer modes of the
// remote-terminal message buffer manager
// assumes a 32-bit avalon-mm bus with byte addresses and a 16-bit shared word ram
package mbm_pkg;

  // register byte addresses
  localparam logic [9:0] ADDR_CTRL    = 10'h000;
  localparam logic [9:0] ADDR_STATUS  = 10'h004;
  localparam logic [9:0] ADDR_EVENT   = 10'h008;
  localparam logic [9:0] ADDR_TTAG    = 10'h00C;
  localparam logic [9:0] ADDR_MC_BASE = 10'h100; // 32 words of mode command data
  localparam logic [9:0] ADDR_DESC    = 10'h200; // 32 entries of four words

  // control register fields
  localparam int CTRL_BSEP_BIT   = 0; // broadcast_separation_option
  localparam int CTRL_BFLAG_BIT  = 1; // broadcast_flag in place of gap error
  localparam int CTRL_SIMPLE_BIT = 2; // simplified mode command storage
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // sticky event fields, write one to clear
  localparam int EV_IDX_DONE   = 0;
  localparam int EV_CIRC1_FULL = 1;
  localparam int EV_CIRC2_DONE = 2;
  localparam int EV_MSG_ERR    = 3;
  localparam logic [3:0] EV_RESET = 4'h0;

  // descriptor word 0 fields
  localparam int DCFG_MODE_LSB = 0;
  localparam int DCFG_SEL_BIT  = 2;
  localparam int DCFG_CNT_LSB  = 8;

  // message info word fields
  localparam int MIW_ERR_LSB  = 11; // timeout, invalid, gap, count, sync in 15:11
  localparam int MIW_GAP_BIT  = 13;
  localparam int MIW_MESSAGE_ERROR_FLAG_BIT = 10;
  localparam int MIW_MODE_BIT = 9;
  localparam int MIW_TX_BIT   = 8;
  localparam int MIW_WC_LSB   = 0;

  // record geometry
  localparam logic [15:0] HDR_WORDS         = 16'h0002;
  localparam logic [5:0]  MAX_DATA_WORDS    = 6'h20;
  localparam logic [4:0]  MODE_NODATA_LIMIT = 5'h10;
  localparam logic [15:0] PP_BUF_WORDS      = 16'h0022;

  typedef enum logic [1:0] {
    MBM_INDEXED  = 2'h0,
    MBM_PINGPONG = 2'h1,
    MBM_CIRC1    = 2'h2,
    MBM_CIRC2    = 2'h3
  } mbm_buf_mode_t;

endpackage : mbm_pkg

// ### verilog/mbm_avs_port.sv
// mbm_avs_port: avalon-mm slave handshake for the buffer manager registers
// assumes the master holds its request until it samples waitrequest low
`timescale 1ns/1ps
`default_nettype none
module mbm_avs_port (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] rd_value,
  output var  logic        avs_waitrequest,
  output var  logic [31:0] avs_readdata,
  output wire logic        reg_wr
);

  // waitrequest drops one cycle after a request is seen, rises again after it
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // read data captured while waitrequest is still high, valid when it drops
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= rd_value;
  end

  // a write takes effect on the edge that completes the transfer
  assign reg_wr = avs_write && !avs_waitrequest;

endmodule : mbm_avs_port
`default_nettype wire

// ### test/mbm_host_ram.sv
// mbm_host_ram: host-side shared word ram facing the buffer manager
// assumes one-cycle read latency; 256 words mirrored over the address
`timescale 1ns/1ps
`default_nettype none
module mbm_host_ram (
  input  wire logic        mclk,
  input  wire logic [15:0] ram_addr,
  input  wire logic [15:0] ram_wdata,
  input  wire logic        ram_we,
  input  wire logic        ram_re,
  output var  logic [15:0] ram_rdata
);
  logic [15:0] mem [256];
  initial ram_rdata = 16'h0000;
  // word store; read data invert when idle so a stale word never passes
  always @(posedge mclk)
  begin
    if (ram_we)
      mem[ram_addr[7:0]] <= ram_wdata;
    ram_rdata <= ram_re ? mem[ram_addr[7:0]] : ~ram_rdata;
  end
endmodule : mbm_host_ram
`default_nettype wire

// ### test/tb_mbm_buffer_manager.sv
// tb_mbm_buffer_manager: random and corner-case records through the buffer manager
// assumes the host ram model and a 200 MHz mclk
`timescale 1ns/1ps
`default_nettype none
module tb_mbm_buffer_manager;
  logic        mclk, rstn, avs_read, avs_write, avs_waitrequest, cmd_valid, cmd_tx;
  logic        rx_valid, tx_req, tx_valid, msg_end, tt_tick, ram_we, ram_re;
  logic        cmd_broadcast_flag, cmd_mode;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [5:0]  cmd_wc;
  logic [4:0]  msg_err, cmd_desc, cmd_code;
  logic [15:0] rx_word, tx_word, ram_addr, ram_wdata, ram_rdata, ttc;
  logic [31:0] lfsr = 32'h0E1D846D;
  logic [15:0] dat [32];
  logic [15:0] txq [$];
  int          err_total = 0, comparisons = 0, cyc = 0;
  mbm_buffer_manager dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .cmd_valid(cmd_valid), .cmd_desc(cmd_desc), .cmd_tx(cmd_tx), .cmd_broadcast_flag(cmd_broadcast_flag),
    .cmd_mode(cmd_mode), .cmd_code(cmd_code), .cmd_wc(cmd_wc), .rx_valid(rx_valid),
    .rx_word(rx_word), .tx_req(tx_req), .tx_valid(tx_valid), .tx_word(tx_word),
    .msg_end(msg_end), .msg_err(msg_err), .tt_tick(tt_tick), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));
  mbm_host_ram mdl (.mclk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // transmit words as they leave, and the hang limit
  always @(posedge mclk)
  begin
    if (tx_valid === 1'b1)
      txq.push_back(tx_word);
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      print_verdict();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // random tick count, command, words, end of message
  task automatic msg(input logic [4:0] d, input logic tx, input logic [5:0] wc,
                     input logic [4:0] er);
    repeat (lfsr[1:0])
    begin
      @(posedge mclk) tt_tick <= 1'b1;
      ttc++;
      lfsr = nxt(lfsr);
    end
    @(posedge mclk) tt_tick <= 1'b0;
    {cmd_valid, cmd_desc, cmd_tx, cmd_wc} <= {1'b1, d, tx, wc};
    for (int i = 0; i < wc; i++)
    begin
      @(posedge mclk) cmd_valid <= 1'b0;
      dat[i] = lfsr[15:0];
      lfsr = nxt(lfsr);
      {rx_word, rx_valid, tx_req} <= {dat[i], !tx, tx};
    end
    @(posedge mclk) {rx_valid, tx_req, cmd_valid} <= 3'h0;
    repeat (4) @(posedge mclk);
    {msg_end, msg_err} <= {1'b1, er};
    @(posedge mclk) msg_end <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : msg
  // stored record at pointer p
  // bf: broadcast flag expected, md: mode command, dp: separate data start
  task automatic rec(input logic [7:0] p, input logic tx, input logic [5:0] wc,
                     input logic [4:0] er, input logic bf = 1'b0, input logic md = 1'b0,
                     input logic [7:0] dp = 8'h00);
    logic [7:0] db;
    db = (dp != 8'h00) ? dp : p + 8'h02;
    chk("info", {16'h0, er | {2'b00, bf, 2'b00}, |er, md, tx, 2'b00, wc}, mdl.mem[p]);
    chk("ttag", ttc, mdl.mem[p + 1]);
    for (int i = 0; i < wc && er == 0 && !tx; i++)
      chk("data", dat[i], mdl.mem[db + i]);
  endtask : rec
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {cmd_valid, cmd_desc, cmd_tx, cmd_wc, rx_valid, rx_word, tx_req} = '0;
    {msg_end, msg_err, tt_tick, ttc, cmd_code, cmd_broadcast_flag, cmd_mode} = '0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    bus(0, mbm_pkg::ADDR_CTRL, 0);
    chk("ctrl", 0, q);
    bus(1, 10'h040, 32'hFFFF);
    bus(0, 10'h040, 0);
    chk("unmapped", 0, q);
    bus(1, 10'h214, 32'h40);
    bus(1, 10'h21C, 32'h70);
    for (int j = 0; j < 3; j++)
    begin
      msg(1, 0, {4'h0, lfsr[1:0]} + 6'h01, j == 1 ? 5'h04 : 5'h00);
      rec(8'h40, 0, cmd_wc, msg_err);
    end
    bus(0, mbm_pkg::ADDR_TTAG, 0);
    chk("ttag reg", ttc, q);
    bus(0, mbm_pkg::ADDR_EVENT, 0);
    chk("err event", 1, q[3]);
    bus(1, 10'h220, 32'h1);
    bus(1, 10'h224, 32'h80);
    bus(1, 10'h228, 32'hA2);
    bus(1, 10'h22C, 32'hD0);
    msg(2, 0, 3, 0);
    rec(8'h80, 0, 3, 0);
    msg(2, 0, 2, 5'h01);
    rec(8'hA2, 0, 2, 5'h01);
    msg(2, 0, 4, 0);
    rec(8'hA2, 0, 4, 0);
    msg(2, 0, 32, 0);
    rec(8'h80, 0, 32, 0);
    bus(1, 10'h240, 32'h2);
    bus(1, 10'h244, 32'hE0);
    bus(1, 10'h248, 32'hE0);
    bus(1, 10'h24C, 32'hE8);
    msg(4, 0, 3, 0);
    rec(8'hE0, 0, 3, 0);
    msg(4, 0, 1, 0);
    rec(8'hE5, 0, 1, 0);
    bus(0, 10'h244, 0);
    chk("circ wrap", 32'hE0, q);
    bus(0, mbm_pkg::ADDR_EVENT, 0);
    chk("full event", 1, q[1]);
    bus(1, 10'h234, 32'h40);
    for (int i = 0; i < 3; i++)
      mdl.mem[8'h42 + i] = lfsr[31:16] ^ 16'(i);
    msg(3, 1, 3, 0);
    chk("tx count", 3, txq.size());
    for (int i = 0; i < 3; i++)
      chk("tx word", mdl.mem[8'h42 + i], txq[i]);
    rec(8'h40, 1, 3, 0);
    bus(1, 10'h270, 32'h100);
    bus(1, 10'h274, 32'h30);
    msg(7, 0, 1, 0);
    rec(8'h30, 0, 1, 0);
    bus(0, 10'h274, 0);
    chk("idx ptr", 32'h33, q);
    bus(0, mbm_pkg::ADDR_EVENT, 0);
    chk("idx event", 1, q[0]);
    bus(1, 10'h250, 32'h103);
    bus(1, 10'h254, 32'h10);
    bus(1, 10'h25C, 32'h20);
    msg(5, 0, 2, 0);
    rec(8'h20, 0, 2, 0, 0, 0, 8'h10);
    bus(0, 10'h254, 0);
    chk("circ2 ptr", 32'h12, q);
    bus(0, mbm_pkg::ADDR_EVENT, 0);
    chk("circ2 event", 1, q[2]);
    {cmd_mode, cmd_code} <= {1'b1, 5'h11};
    msg(2, 0, 1, 0);
    rec(8'hA2, 0, 1, 0, 0, 1);
    bus(1, mbm_pkg::ADDR_CTRL, 32'h4);
    msg(6, 0, 1, 0);
    bus(0, 10'h118, 0);
    chk("mode data", dat[0], q);
    bus(1, mbm_pkg::ADDR_CTRL, 32'h3);
    {cmd_mode, cmd_broadcast_flag} <= 2'h1;
    msg(1, 0, 2, 0);
    rec(8'h70, 0, 2, 0, 1);
    print_verdict();
  end
endmodule : tb_mbm_buffer_manager
`default_nettype wire
